/* File: rtl/call_stack.sv */
// Circular hardware call stack with push and pop
module call_stack #(
  parameter int DEPTH  = move_rotate_return_pkg::STACK_DEPTH,
  parameter int WIDTH  = move_rotate_return_pkg::PC_W
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Stack operations
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         push_data,
  input  wire logic                     pop,
  // State
  output logic      [WIDTH-1:0]         top,
  output logic      [$clog2(DEPTH)-1:0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    ptr_reg;
  logic [PW-1:0]    top_idx;

  assign top_idx = ptr_reg - PW'(1);
  assign top     = mem[top_idx];
  assign level   = ptr_reg;

  // Pointer wraps around
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_reg <= '0;
    end else if (push && !pop) begin
      ptr_reg <= ptr_reg + PW'(1);
    end else if (pop && !push) begin
      ptr_reg <= top_idx;
    end
  end

  // Push with pop replaces the top entry
  always_ff @(posedge sys_clk) begin
    if (push && pop) begin
      mem[top_idx] <= push_data;
    end else if (push) begin
      mem[ptr_reg] <= push_data;
    end
  end
endmodule

/* File: rtl/move_rotate_return_exec.sv */
// Execution of move, idle, rotate and return instructions
module move_rotate_return_exec #(
  parameter int STACK_DEPTH = move_rotate_return_pkg::STACK_DEPTH
) (
  // Clock and reset
  input  wire logic                                     sys_clk,
  input  wire logic                                     rst,
  // Instruction and operand
  input  wire logic                                     instr_valid,
  input  wire logic [move_rotate_return_pkg::WORD_W-1:0] instr_word,
  input  wire logic [move_rotate_return_pkg::DATA_W-1:0] file_rdata,
  output logic                                          instr_ready,
  output logic                                          done,
  output logic                                          unhandled,
  // Call stack push from call logic
  input  wire logic                                     call_push,
  input  wire logic [move_rotate_return_pkg::PC_W-1:0]   call_addr,
  // Interrupt entry clears the enable
  input  wire logic                                     int_enable_clear,
  // File register write back
  output logic                                          file_we,
  output logic      [move_rotate_return_pkg::ADDR_W-1:0] file_waddr,
  output logic      [move_rotate_return_pkg::DATA_W-1:0] file_wdata,
  // Core state
  output logic      [move_rotate_return_pkg::DATA_W-1:0] acc,
  output logic                                          zero_flag,
  output logic                                          carry_flag,
  output logic                                          global_interrupt_enable,
  output logic      [move_rotate_return_pkg::PC_W-1:0]   pc
);
  localparam int DW = move_rotate_return_pkg::DATA_W;
  localparam int AW = move_rotate_return_pkg::ADDR_W;
  localparam int PW = move_rotate_return_pkg::PC_W;

  function automatic move_rotate_return_pkg::op_type decode(input logic [13:0] w);
    move_rotate_return_pkg::op_type r;
    r = move_rotate_return_pkg::op_other;
    if ((w & move_rotate_return_pkg::OPC_MOVE_MASK) == move_rotate_return_pkg::OPC_MOVE) begin
      r = move_rotate_return_pkg::op_move;
    end else if ((w & move_rotate_return_pkg::OPC_MOVE_MASK) == move_rotate_return_pkg::OPC_ROT_LEFT) begin
      r = move_rotate_return_pkg::op_rotate_left;
    end else if ((w & move_rotate_return_pkg::OPC_MOVE_MASK) == move_rotate_return_pkg::OPC_ROT_RIGHT) begin
      r = move_rotate_return_pkg::op_rotate_right;
    end else if (w == move_rotate_return_pkg::OPC_RET_INT) begin
      r = move_rotate_return_pkg::op_return_interrupt;
    end else if ((w & move_rotate_return_pkg::OPC_IDLE_MASK) == move_rotate_return_pkg::OPC_IDLE) begin
      r = move_rotate_return_pkg::op_idle;
    end else if ((w & move_rotate_return_pkg::OPC_RET_IMM_MSK) == move_rotate_return_pkg::OPC_RET_IMM) begin
      r = move_rotate_return_pkg::op_return_immediate;
    end
    return r;
  endfunction

  move_rotate_return_pkg::op_type    op_now;
  move_rotate_return_pkg::state_type state_reg;
  logic                              accept;
  logic                              dest_file;
  logic                              is_return;
  logic [AW-1:0]                     f_addr;
  logic [DW-1:0]                     rot_left_val;
  logic [DW-1:0]                     rot_right_val;
  logic [PW-1:0]                     stack_top;
  logic [$clog2(STACK_DEPTH)-1:0]    stack_level;

  logic          instr_ready_reg;
  logic          done_reg;
  logic          unhandled_reg;
  logic          file_we_reg;
  logic [AW-1:0] file_waddr_reg;
  logic [DW-1:0] file_wdata_reg;
  logic [DW-1:0] acc_reg;
  logic          zero_reg;
  logic          carry_reg;
  logic          int_enable_reg;
  logic [PW-1:0] pc_reg;

  assign op_now        = decode(instr_word);
  assign accept        = instr_valid && instr_ready_reg;
  assign dest_file     = instr_word[move_rotate_return_pkg::DEST_BIT];
  assign f_addr        = instr_word[AW-1:0];
  assign rot_left_val  = {file_rdata[DW-2:0], carry_reg};
  assign rot_right_val = {carry_reg, file_rdata[DW-1:1]};
  assign is_return     = accept && (op_now == move_rotate_return_pkg::op_return_interrupt ||
                                    op_now == move_rotate_return_pkg::op_return_immediate);

  call_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PW)
  ) u_stack (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .push      (call_push),
    .push_data (call_addr),
    .pop       (is_return),
    .top       (stack_top),
    .level     (stack_level)
  );

  // Sequencing of two-cycle returns
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg       <= move_rotate_return_pkg::st_execute;
      instr_ready_reg <= 1'b1;
      done_reg        <= 1'b0;
    end else begin
      unique case (state_reg)
        move_rotate_return_pkg::st_execute: begin
          if (is_return) begin
            state_reg       <= move_rotate_return_pkg::st_flush;
            instr_ready_reg <= 1'b0;
            done_reg        <= 1'b0;
          end else begin
            done_reg <= accept;
          end
        end
        move_rotate_return_pkg::st_flush: begin
          state_reg       <= move_rotate_return_pkg::st_execute;
          instr_ready_reg <= 1'b1;
          done_reg        <= 1'b1;
        end
      endcase
    end
  end

  // Accumulator and file write back
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_reg        <= move_rotate_return_pkg::ACC_RESET;
      file_we_reg    <= 1'b0;
      file_waddr_reg <= '0;
      file_wdata_reg <= '0;
      unhandled_reg  <= 1'b0;
    end else begin
      file_we_reg   <= 1'b0;
      unhandled_reg <= accept && op_now == move_rotate_return_pkg::op_other;
      if (accept) begin
        unique case (op_now)
          move_rotate_return_pkg::op_move: begin
            if (dest_file) begin
              file_we_reg    <= 1'b1;
              file_waddr_reg <= f_addr;
              file_wdata_reg <= file_rdata;
            end else begin
              acc_reg <= file_rdata;
            end
          end
          move_rotate_return_pkg::op_rotate_left: begin
            if (dest_file) begin
              file_we_reg    <= 1'b1;
              file_waddr_reg <= f_addr;
              file_wdata_reg <= rot_left_val;
            end else begin
              acc_reg <= rot_left_val;
            end
          end
          move_rotate_return_pkg::op_rotate_right: begin
            if (dest_file) begin
              file_we_reg    <= 1'b1;
              file_waddr_reg <= f_addr;
              file_wdata_reg <= rot_right_val;
            end else begin
              acc_reg <= rot_right_val;
            end
          end
          move_rotate_return_pkg::op_return_immediate: begin
            acc_reg <= instr_word[DW-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Status flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_reg  <= move_rotate_return_pkg::FLAG_RESET;
      carry_reg <= move_rotate_return_pkg::FLAG_RESET;
    end else if (accept) begin
      if (op_now == move_rotate_return_pkg::op_move) begin
        zero_reg <= (file_rdata == '0);
      end
      if (op_now == move_rotate_return_pkg::op_rotate_left) begin
        carry_reg <= file_rdata[DW-1];
      end
      if (op_now == move_rotate_return_pkg::op_rotate_right) begin
        carry_reg <= file_rdata[0];
      end
    end
  end

  // Interrupt enable, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_enable_reg <= move_rotate_return_pkg::INT_EN_RESET;
    end else if (accept && op_now == move_rotate_return_pkg::op_return_interrupt) begin
      int_enable_reg <= 1'b1;
    end else if (int_enable_clear) begin
      int_enable_reg <= 1'b0;
    end
  end

  // Program counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_reg <= move_rotate_return_pkg::PC_RESET;
    end else if (is_return) begin
      pc_reg <= stack_top;
    end else if (accept) begin
      pc_reg <= pc_reg + PW'(1);
    end
  end

  assign instr_ready             = instr_ready_reg;
  assign done                    = done_reg;
  assign unhandled               = unhandled_reg;
  assign file_we                 = file_we_reg;
  assign file_waddr              = file_waddr_reg;
  assign file_wdata              = file_wdata_reg;
  assign acc                     = acc_reg;
  assign zero_flag               = zero_reg;
  assign carry_flag              = carry_reg;
  assign global_interrupt_enable = int_enable_reg;
  assign pc                      = pc_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_take(move_rotate_return_pkg::op_type o);
    accept && op_now == o;
  endsequence

  sequence s_return_wait;
    !instr_ready_reg && !done_reg ##1 instr_ready_reg && done_reg;
  endsequence

  a_move_to_acc: assert property (s_take(move_rotate_return_pkg::op_move) ##0 !dest_file |=>
    acc_reg == $past(file_rdata) && !file_we_reg) else $error("move to accumulator wrong");
  a_move_to_file: assert property (s_take(move_rotate_return_pkg::op_move) ##0 dest_file |=>
    file_we_reg && file_wdata_reg == $past(file_rdata) && file_waddr_reg == $past(f_addr) && $stable(acc_reg))
    else $error("move to file wrong");
  a_move_zero_flag: assert property (s_take(move_rotate_return_pkg::op_move) |=>
    zero_reg == ($past(file_rdata) == 8'h00) && $stable(carry_reg)) else $error("zero flag wrong");
  a_imm_acc_flags: assert property (s_take(move_rotate_return_pkg::op_return_immediate) |=>
    acc_reg == $past(instr_word[DW-1:0]) && $stable(zero_reg) && $stable(carry_reg)) else $error("immediate return wrong");
  a_imm_pc_load: assert property (s_take(move_rotate_return_pkg::op_return_immediate) |=>
    pc_reg == $past(stack_top)) else $error("return counter wrong");
  a_return_two_cycle: assert property (is_return |=> s_return_wait)
    else $error("return not two cycles");
  a_rotate_left: assert property (s_take(move_rotate_return_pkg::op_rotate_left) |=>
    carry_reg == $past(file_rdata[7]) && $stable(zero_reg) &&
    (file_we_reg ? file_wdata_reg : acc_reg) == {$past(file_rdata[6:0]), $past(carry_reg)} &&
    file_we_reg == $past(dest_file)) else $error("rotate left wrong");
  a_rotate_right: assert property (s_take(move_rotate_return_pkg::op_rotate_right) |=>
    carry_reg == $past(file_rdata[0]) && $stable(zero_reg) &&
    (file_we_reg ? file_wdata_reg : acc_reg) == {$past(carry_reg), $past(file_rdata[7:1])} &&
    file_we_reg == $past(dest_file)) else $error("rotate right wrong");
  a_stack_pop: assert property (is_return && !call_push |=>
    stack_level == $past(stack_level) - 1'b1) else $error("stack not popped");
  a_int_return: assert property (s_take(move_rotate_return_pkg::op_return_interrupt) |=>
    global_interrupt_enable && pc_reg == $past(stack_top) && $stable(zero_reg) && $stable(carry_reg))
    else $error("interrupt return wrong");
  a_idle_nothing: assert property (s_take(move_rotate_return_pkg::op_idle) |=>
    pc_reg == $past(pc_reg) + 13'h0001 && !file_we_reg && $stable(acc_reg) && $stable(zero_reg) &&
    $stable(carry_reg)) else $error("idle changed state");
endmodule

/* File: rtl/move_rotate_return_pkg.sv */
// Constants and types for the move, rotate and return execution slice
package move_rotate_return_pkg;
  localparam int WORD_W      = 14;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  localparam int DEST_BIT    = 7;

  localparam logic [13:0] OPC_MOVE_MASK   = 14'h3f00;
  localparam logic [13:0] OPC_MOVE        = 14'h0800;
  localparam logic [13:0] OPC_ROT_LEFT    = 14'h0d00;
  localparam logic [13:0] OPC_ROT_RIGHT   = 14'h0c00;
  localparam logic [13:0] OPC_IDLE_MASK   = 14'h3f9f;
  localparam logic [13:0] OPC_IDLE        = 14'h0000;
  localparam logic [13:0] OPC_RET_INT     = 14'h0009;
  localparam logic [13:0] OPC_RET_IMM_MSK = 14'h3c00;
  localparam logic [13:0] OPC_RET_IMM     = 14'h3400;

  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic        INT_EN_RESET = 1'b0;
  localparam logic        FLAG_RESET   = 1'b0;

  typedef enum {
    op_move,
    op_idle,
    op_return_interrupt,
    op_return_immediate,
    op_rotate_left,
    op_rotate_right,
    op_other
  } op_type;

  typedef enum {
    st_execute,
    st_flush
  } state_type;
endpackage

/* File: verification/move_rotate_return_exec_tb.sv */
// Self-checking testbench for the move, rotate and return execution slice
module move_rotate_return_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        instr_valid = 1'b0;
  logic [13:0] instr_word  = 14'h0000;
  logic [7:0]  file_rdata  = 8'h00;
  logic        call_push   = 1'b0;
  logic [12:0] call_addr   = 13'h0000;
  logic        int_enable_clear = 1'b0;
  logic        instr_ready, done, unhandled, file_we, zero_flag, carry_flag, int_enable;
  logic [6:0]  file_waddr;
  logic [7:0]  file_wdata, acc;
  logic [12:0] pc;
  int          n_fail     = 0;
  int          num_checks = 0;
  int          seed       = 32'hc500ca81;
  // Reference state
  logic [7:0]  m_acc;
  logic [7:0]  mem [128];
  logic        m_z, m_c, m_ie;
  logic [12:0] m_pc;
  logic [12:0] stk [8];
  logic [2:0]  sp;
  int          depth;

  always #12.5 sys_clk = ~sys_clk;

  move_rotate_return_exec #(.STACK_DEPTH(8)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rdata(file_rdata), .instr_ready(instr_ready), .done(done), .unhandled(unhandled),
    .call_push(call_push), .call_addr(call_addr), .int_enable_clear(int_enable_clear), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .global_interrupt_enable(int_enable), .pc(pc));

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_state();
    chk(16'(acc), 16'(m_acc));
    chk(16'(zero_flag), 16'(m_z));
    chk(16'(carry_flag), 16'(m_c));
    chk(16'(int_enable), 16'(m_ie));
    chk(16'(pc), 16'(m_pc));
  endtask

  task automatic model_reset();
    m_acc = 8'h00;
    m_z   = 1'b0;
    m_c   = 1'b0;
    m_ie  = 1'b0;
    m_pc  = 13'h0000;
    sp    = 3'h0;
    depth = 0;
  endtask

  // Stack push and interrupt-entry pulse, with no instruction offered
  task automatic side(input logic p, input logic g, input logic [12:0] a);
    instr_valid = 1'b0;
    call_push   = p;
    int_enable_clear = g;
    call_addr   = a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    call_push = 1'b0;
    int_enable_clear = 1'b0;
    if (p) begin
      sp      = sp + 3'h1;
      stk[sp] = a;
      if (depth < 8) depth++;
    end
    if (g) m_ie = 1'b0;
    check_state();
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Op codes: 0 move, 1 idle, 2 interrupt return, 3 immediate return, 4 rotate left, 5 rotate right, 6 other
  task automatic exec(input int op, input logic [6:0] f, input logic d, input logic [7:0] k);
    logic [7:0]  v;
    logic [7:0]  res;
    logic [13:0] w;
    logic        we;
    v   = mem[f];
    res = v;
    we  = 1'b0;
    case (op)
      0: begin
        w   = move_rotate_return_pkg::OPC_MOVE | {6'h00, d, f};
        m_z = (v == 8'h00);
      end
      1: w = move_rotate_return_pkg::OPC_IDLE | {7'h00, k[1:0], 5'h00};
      2: w = move_rotate_return_pkg::OPC_RET_INT;
      3: w = move_rotate_return_pkg::OPC_RET_IMM | {6'h00, k};
      4: begin
        w   = move_rotate_return_pkg::OPC_ROT_LEFT | {6'h00, d, f};
        res = {v[6:0], m_c};
        m_c = v[7];
      end
      5: begin
        w   = move_rotate_return_pkg::OPC_ROT_RIGHT | {6'h00, d, f};
        res = {m_c, v[7:1]};
        m_c = v[0];
      end
      default: w = 14'h0700 | {7'h00, f};
    endcase
    if (op == 0 || op == 4 || op == 5) begin
      if (d) we = 1'b1;
      else m_acc = res;
    end
    instr_valid = 1'b1;
    instr_word  = w;
    file_rdata  = v;
    @(posedge sys_clk);
    @(negedge sys_clk);
    if (op == 2 || op == 3) begin
      m_pc = stk[sp];
      if (call_push) begin
        stk[sp] = call_addr;
      end else begin
        sp    = sp - 3'h1;
        depth = depth - 1;
      end
      call_push        = 1'b0;
      int_enable_clear = 1'b0;
      if (op == 3) m_acc = k;
      if (op == 2) m_ie = 1'b1;
      check_state();
      chk(16'(instr_ready), 16'h0000);
      chk(16'(done), 16'h0000);
      instr_word = move_rotate_return_pkg::OPC_IDLE;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(16'(done), 16'h0001);
      chk(16'(instr_ready), 16'h0001);
      check_state();
    end else begin
      m_pc = m_pc + 13'h0001;
      if (we) mem[f] = res;
      chk(16'(done), 16'h0001);
      chk(16'(unhandled), 16'(op == 6));
      chk(16'(file_we), 16'(we));
      if (we) begin
        chk(16'(file_waddr), 16'(f));
        chk(16'(file_wdata), 16'(res));
      end
      check_state();
    end
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    int          op;
    for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
    model_reset();
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    chk(16'(instr_ready), 16'h0001);
    check_state();
    // Corner cases
    mem[5] = 8'h00;
    mem[6] = 8'h80;
    mem[7] = 8'h01;
    exec(0, 7'h05, 1'b1, 8'h00);
    exec(0, 7'h07, 1'b0, 8'h00);
    exec(4, 7'h06, 1'b1, 8'h00);
    exec(5, 7'h07, 1'b0, 8'h00);
    exec(4, 7'h05, 1'b0, 8'h00);
    side(1'b1, 1'b1, 13'h1fff);
    side(1'b1, 1'b0, 13'h0123);
    call_push = 1'b1;
    call_addr = 13'h0abc;
    exec(3, 7'h00, 1'b0, 8'hff);
    int_enable_clear = 1'b1;
    exec(2, 7'h00, 1'b0, 8'h00);
    exec(1, 7'h00, 1'b0, 8'h03);
    exec(6, 7'h7f, 1'b0, 8'h00);
    // Random traffic
    repeat (500) begin
      r  = $random(seed);
      op = int'(r[15:0] % 16'd7);
      if (r[20:18] == 3'h0 || ((op == 2 || op == 3) && depth == 0)) begin
        side(1'b1, r[21], r[12:0]);
      end
      exec(op, r[28:22], r[29], r[7:0]);
    end
    // Reset in mid-run
    rst = 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    model_reset();
    chk(16'(done), 16'h0000);
    check_state();
    exec(0, 7'h06, 1'b0, 8'h00);
    end_of_test();
  end
endmodule
